// ===== verif/tb_top.sv
// self-checking bench: axi4-lite master, bus slave model, expected codes
// assumes the checker is bound to twc_ctrl and rate stays below 4
`timescale 1ns/1ps
module tb_top
  import twc_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cpu_gie = 1'b1, nack = 1'b0, jam = 1'b0, ce = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, d, seed = 32'h0000_9d59;
  logic awready, wready, bvalid, arready, rvalid, irq, pull, scl_w, sda_w;
  logic [1:0] bresp, rresp, r, ps;
  logic [7:0] rxb;
  logic [7:0] bq[$];
  twc_line_out_type lo;
  twc_line_in_type li;
  int miscompares = 0, samples_checked = 0;
  int w;
  always #12.5 clk_sys = ~clk_sys;
  assign scl_w = !lo.scl_oe;
  assign sda_w = !(lo.sda_oe || pull || jam);
  assign li = '{scl: scl_w, sda: sda_w};
  twc_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .cpu_gie(cpu_gie), .irq(irq), .line_in(li), .line_out(lo));
  twc_slave_model slv (.scl(scl_w), .sda(sda_w), .nack(nack), .pull(pull), .rx_byte(rxb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tmo;
    miscompares++;
    results();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    int i;
    @(posedge clk_sys);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= v; bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 64) tmo();
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    int i;
    @(posedge clk_sys);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 64) tmo();
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask
  // software polls the flag, irq not relied on
  task poll;
    int i;
    for (i = 0; i < 200; i++) begin
      rd(OFS_CTRL);
      if (d[CB_FLAG] === 1'b1) break;
    end
    if (i == 200) tmo();
  endtask
  task send(input logic [7:0] v, input logic nk, input logic [7:0] code);
    nack <= nk;
    wr(OFS_DATA, {24'h00_0000, v});
    rd(OFS_DATA);
    chk(d, {24'h00_0000, v});
    bq.push_back(v);
    wr(OFS_CTRL, 32'h0000_0085);
    poll();
    rd(OFS_STAT);
    chk(d & 32'h0000_00f8, {24'h00_0000, code});
    chk({24'h00_0000, rxb}, {24'h00_0000, bq.pop_front()});
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(OFS_STAT);
    chk(d, 32'h0000_00f8);
    rd(4'h2);
    chk(32'(r), 32'(RESP_SLVERR));
    seed = lfsr(seed);
    wr(OFS_RATE, {30'h0000_0000, seed[1:0]});
    chk(32'(r), 32'(RESP_OKAY));
    rd(OFS_RATE);
    chk(d, {30'h0000_0000, seed[1:0]});
    ps = seed[3:2];
    wr(OFS_STAT, {30'h0000_0000, ps});
    wr(4'h2, 32'h0000_00ff);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(OFS_STAT);
    chk(d, {24'h00_0000, CODE_NONE[7:2], ps});
    $display("test registers done");
    wr(OFS_CTRL, 32'h0000_0025);
    repeat (60) @(posedge clk_sys);
    rd(OFS_CTRL);
    chk(d, 32'h0000_0025);
    $display("test settings only done");
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, 32'h0000_00a5);
      // frozen engine must not finish the start
      ce <= 1'b0;
      repeat (60) @(posedge clk_sys);
      chk(32'(irq), 32'h0000_0000);
      ce <= 1'b1;
      poll();
      rd(OFS_STAT);
      chk(d & 32'h0000_00f8, {24'h00_0000, CODE_START});
      chk(32'(irq), 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0005);
      repeat (20) @(posedge clk_sys);
      rd(OFS_CTRL);
      chk(32'(d[CB_FLAG]), 32'h0000_0001);
      chk(32'(scl_w), 32'h0000_0000);
      seed = lfsr(seed);
      send({seed[7:1], 1'b0}, k[0], k[0] ? CODE_SLAW_NACK : CODE_SLAW_ACK);
      seed = lfsr(seed);
      send(seed[7:0], !k[0], k[0] ? CODE_DATA_ACK : CODE_DATA_NACK);
      cpu_gie <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h0000_0000);
      cpu_gie <= 1'b1;
      wr(OFS_CTRL, 32'h0000_0095);
      repeat (80) @(posedge clk_sys);
      rd(OFS_CTRL);
      chk(32'(d[CB_FLAG]), 32'h0000_0000);
      rd(OFS_STAT);
      chk(d, {24'h00_0000, CODE_NONE[7:2], ps});
      chk(32'({scl_w, sda_w}), 32'h0000_0003);
      $display("test transfer %0d done", k);
    end
    wr(OFS_CTRL, 32'h0000_00a5);
    poll();
    wr(OFS_DATA, 32'h0000_00a4);
    wr(OFS_CTRL, 32'h0000_0085);
    // stray sda fall while the first bit clock is high
    for (w = 0; w < 100; w++) begin
      @(posedge clk_sys);
      if (scl_w) break;
    end
    if (w == 100) tmo();
    jam <= 1'b1;
    poll();
    rd(OFS_STAT);
    chk(d & 32'h0000_00f8, {24'h00_0000, CODE_BUS_ERR});
    chk(32'(scl_w), 32'h0000_0000);
    jam <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0095);
    repeat (80) @(posedge clk_sys);
    rd(OFS_CTRL);
    chk(32'(d[CB_FLAG]), 32'h0000_0000);
    chk(32'({scl_w, sda_w}), 32'h0000_0003);
    $display("test bus error done");
    results();
  end
endmodule

// ===== verif/twc_ctrl_checker.sv
// assertions on the two-wire controller ports: axi timing, irq gating, clock hold
// assumes ce is low only while no bus request is open, and a bus rate of at most 3
`timescale 1ns/1ps
module twc_ctrl_checker
  import twc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // axi write
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // axi read
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // cpu and bus
  input wire logic cpu_gie,
  input wire logic irq,
  input twc_line_out_type line_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr_hs;
  logic ctl_wr;
  assign wr_hs = awvalid && awready && wvalid && wready;
  assign ctl_wr = wr_hs && awaddr == OFS_CTRL;
  wr_late_a: assert property (wr_hs |-> ##2 bvalid)
    else $error("write answer not two edges after take");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rd_late_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  irq_gate_a: assert property (irq |-> $past(cpu_gie))
    else $error("irq without global enable");
  irq_off_a: assert property (!cpu_gie |=> !irq)
    else $error("irq stays with global enable off");
  scl_hold_a: assert property (irq |-> line_out.scl_oe)
    else $error("clock released while flag set");
  no_clear_a: assert property (irq && ctl_wr && !wdata[CB_FLAG] |-> line_out.scl_oe [*4])
    else $error("zero flag write released the bus");
  stop_quiet_a: assert property (ctl_wr && wdata[CB_FLAG] && wdata[CB_STOP] &&
      !wdata[CB_START] |-> ##40 !irq)
    else $error("flag set after stop");
  od_low_a: assert property (!line_out.scl_o && !line_out.sda_o)
    else $error("open drain output level not low");
  cover property (ctl_wr && wdata[CB_START]);
  cover property ($rose(irq));
  cover property (bvalid && bresp == RESP_SLVERR);
endmodule
bind twc_ctrl twc_ctrl_checker chk_i (.clk_sys(clk_sys), .nrst(nrst), .awvalid(awvalid),
  .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .cpu_gie(cpu_gie), .irq(irq),
  .line_out(line_out));

// ===== verif/twc_slave_model.sv
// behavioural slave on the two-wire bus, acks or nacks the ninth clock
// assumes resolved levels with pull-ups and scl made only by the master
`timescale 1ns/1ps
module twc_slave_model (
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // nack request, sda pull and last byte seen
  input wire logic nack,
  output logic pull,
  output logic [7:0] rx_byte
);
  int cnt = -1;
  logic [7:0] sh = 8'h00;
  initial pull = 1'b0;
  initial rx_byte = 8'h00;
  // start or stop restarts the count
  always @(sda) if (scl) cnt = -1;
  always @(posedge scl) if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
  always @(negedge scl) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    pull <= (cnt == 8) && !nack;
    if (cnt == 8) rx_byte <= sh;
  end
endmodule

// ===== verilog/twc_ctrl.sv
// two-wire controller, master transmitter with software handshake over axi4-lite
// assumes open-drain scl/sda with pull-ups outside; cpu_gie comes from the clk_sys domain
`timescale 1ns/1ps
module twc_ctrl
  import twc_pkg::*;
(
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // cpu side
  input wire logic cpu_gie,
  output logic irq,
  // bus lines
  input twc_line_in_type line_in,
  output twc_line_out_type line_out
);

  twc_regs_type r_reg;
  twc_regs_type r_next;
  logic scl_s;
  logic sda_s;

  twc_sync2 u_sync_scl (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .d(line_in.scl),
    .q(scl_s)
  );

  twc_sync2 u_sync_sda (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .d(line_in.sda),
    .q(sda_s)
  );

  always_comb begin
    logic wr;
    logic launch;
    logic set_ev;
    logic [8:0] reload;
    r_next = r_reg;
    wr = r_reg.aw_got & r_reg.w_got;
    launch = 1'b0;
    set_ev = 1'b0;
    reload = {1'b0, r_reg.rate} + QUARTER_MIN;

    // write channel capture, either order
    if (awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_addr = awaddr;
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.w_data = wdata[7:0];
      r_next.w_lane = wstrb[0];
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end

    if (wr) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      if (r_reg.aw_addr == OFS_CTRL) begin
        if (r_reg.w_lane) begin
          r_next.ack_en = r_reg.w_data[CB_ACK];
          r_next.start = r_reg.w_data[CB_START];
          r_next.stop = r_reg.w_data[CB_STOP];
          r_next.en = r_reg.w_data[CB_EN];
          r_next.irq_en = r_reg.w_data[CB_IE];
          if (r_reg.w_data[CB_FLAG]) begin
            r_next.flag = 1'b0;
            launch = r_reg.w_data[CB_EN];
          end
        end
      end else if (r_reg.aw_addr == OFS_DATA) begin
        if (r_reg.w_lane) begin
          r_next.data = r_reg.w_data;
        end
      end else if (r_reg.aw_addr == OFS_RATE) begin
        if (r_reg.w_lane) begin
          r_next.rate = r_reg.w_data;
        end
      end else if (r_reg.aw_addr == OFS_STAT) begin
        if (r_reg.w_lane) begin
          r_next.presc = r_reg.w_data[1:0];
        end
      end else begin
        r_next.bresp = RESP_SLVERR;
      end
    end

    // read channel
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      if (araddr == OFS_CTRL) begin
        r_next.rdata[CB_FLAG] = r_reg.flag;
        r_next.rdata[CB_ACK] = r_reg.ack_en;
        r_next.rdata[CB_START] = r_reg.start;
        r_next.rdata[CB_STOP] = r_reg.stop;
        r_next.rdata[CB_EN] = r_reg.en;
        r_next.rdata[CB_IE] = r_reg.irq_en;
      end else if (araddr == OFS_STAT) begin
        r_next.rdata[7:0] = {r_reg.code, 1'b0, r_reg.presc};
      end else if (araddr == OFS_DATA) begin
        r_next.rdata[7:0] = r_reg.data;
      end else if (araddr == OFS_RATE) begin
        r_next.rdata[7:0] = r_reg.rate;
      end else begin
        r_next.rresp = RESP_SLVERR;
      end
    end

    // bus engine
    if (!r_reg.en && !launch) begin
      r_next.st = ST_IDLE;
      r_next.scl_oe = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.q = 2'd0;
    end else begin
      unique case (r_reg.st)
        ST_IDLE, ST_HOLD: begin
          if (r_reg.st == ST_HOLD) begin
            r_next.scl_oe = 1'b1;
          end
          if (launch) begin
            r_next.q = 2'd0;
            r_next.qcnt = reload;
            if (r_reg.w_data[CB_START]) begin
              r_next.st = ST_START;
              r_next.rep = (r_reg.st == ST_HOLD);
              r_next.sda_oe = 1'b0;
            end else if (r_reg.st == ST_HOLD && r_reg.w_data[CB_STOP]) begin
              r_next.st = ST_STOP;
              r_next.sda_oe = 1'b1;
            end else if (r_reg.st == ST_HOLD) begin
              r_next.st = ST_BYTE;
              r_next.shift = r_reg.data;
              r_next.bitn = 4'd0;
              r_next.sda_oe = !r_reg.data[7];
              if (r_reg.addr_phase) begin
                r_next.addr_rd = r_reg.data[0];
              end
            end
          end
        end
        default: begin
          if (r_reg.st == ST_BYTE && (r_reg.q == 2'd1 || r_reg.q == 2'd2) && scl_s
              && sda_s != r_reg.sda_prev) begin
            // sda moved while scl high: stray start or stop
            set_ev = 1'b1;
            r_next.code_pend = CODE_BUS_ERR[7:3];
            // park with scl low; software recovers with a stop or a start
            r_next.st = ST_HOLD;
            r_next.addr_phase = 1'b0;
            r_next.scl_oe = 1'b1;
            r_next.sda_oe = 1'b0;
          end else if (r_reg.qcnt != 9'h000) begin
            r_next.qcnt = r_reg.qcnt - 9'h001;
          end else if (!(r_reg.q == 2'd1 && !scl_s)) begin
            // quarter ends; q1 waits while a slave stretches scl
            r_next.qcnt = reload;
            r_next.q = r_reg.q + 2'd1;
            unique case (r_reg.st)
              ST_START: begin
                unique case (r_reg.q)
                  2'd0: r_next.scl_oe = 1'b0;
                  2'd1: r_next.sda_oe = 1'b1;
                  2'd2: r_next.scl_oe = 1'b1;
                  2'd3: begin
                    set_ev = 1'b1;
                    r_next.code_pend = r_reg.rep ? CODE_REP_START[7:3] : CODE_START[7:3];
                    r_next.st = ST_HOLD;
                    r_next.addr_phase = 1'b1;
                  end
                endcase
              end
              ST_BYTE: begin
                unique case (r_reg.q)
                  2'd0: r_next.scl_oe = 1'b0;
                  2'd1: begin
                    if (r_reg.bitn == LAST_BIT) begin
                      r_next.acked = !sda_s;
                    end
                  end
                  2'd2: r_next.scl_oe = 1'b1;
                  2'd3: begin
                    if (r_reg.bitn == LAST_BIT) begin
                      set_ev = 1'b1;
                      r_next.st = ST_HOLD;
                      r_next.addr_phase = 1'b0;
                      if (r_reg.addr_phase && r_reg.addr_rd) begin
                        r_next.code_pend = r_reg.acked ? CODE_SLAR_ACK[7:3] : CODE_SLAR_NACK[7:3];
                      end else if (r_reg.addr_phase) begin
                        r_next.code_pend = r_reg.acked ? CODE_SLAW_ACK[7:3] : CODE_SLAW_NACK[7:3];
                      end else begin
                        r_next.code_pend = r_reg.acked ? CODE_DATA_ACK[7:3] : CODE_DATA_NACK[7:3];
                      end
                    end else begin
                      r_next.bitn = r_reg.bitn + 4'd1;
                      r_next.shift = {r_reg.shift[6:0], 1'b0};
                      // release sda for the acknowledge slot
                      r_next.sda_oe = (r_reg.bitn == 4'd7) ? 1'b0 : !r_reg.shift[6];
                    end
                  end
                endcase
              end
              ST_STOP: begin
                unique case (r_reg.q)
                  2'd0: r_next.scl_oe = 1'b0;
                  2'd1: r_next.sda_oe = 1'b0;
                  2'd2: r_next.sda_oe = 1'b0;
                  2'd3: r_next.st = ST_IDLE;
                endcase
              end
              default: r_next.st = ST_IDLE;
            endcase
          end
        end
      endcase
    end

    // event set wins over a clear in the same cycle
    if (set_ev) begin
      r_next.flag = 1'b1;
    end
    r_next.code = r_reg.flag ? r_reg.code_pend : CODE_NONE[7:3];
    r_next.irq = r_next.flag & r_next.irq_en & cpu_gie;
    r_next.sda_prev = sda_s;
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.code <= CODE_NONE[7:3];
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign awready = r_reg.awready;
  assign wready = r_reg.wready;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.arready;
  assign rvalid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign rresp = r_reg.rresp;
  assign irq = r_reg.irq;
  assign line_out = '{scl_o: 1'b0, scl_oe: r_reg.scl_oe, sda_o: 1'b0, sda_oe: r_reg.sda_oe};

endmodule

// ===== verilog/twc_pkg.sv
// package for the two-wire controller: register map, control fields, status codes, state types
// assumes a 32-bit axi4-lite slave port with a 4-bit byte address
package twc_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_RATE = 4'hC;

  // control register field positions
  localparam int CB_FLAG = 7;
  localparam int CB_ACK = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP = 4;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;

  // status codes, upper five bits are the code, low bits hold the prescaler
  localparam logic [7:0] CODE_BUS_ERR = 8'h00;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_REP_START = 8'h10;
  localparam logic [7:0] CODE_SLAW_ACK = 8'h18;
  localparam logic [7:0] CODE_SLAW_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_SLAR_ACK = 8'h40;
  localparam logic [7:0] CODE_SLAR_NACK = 8'h48;
  localparam logic [7:0] CODE_NONE = 8'hF8;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one less than the shortest quarter of a serial clock period in clk_sys cycles, added to the rate register
  localparam logic [8:0] QUARTER_MIN = 9'h004;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BYTE = 3'b011,
    ST_HOLD = 3'b010,
    ST_STOP = 3'b110
  } twc_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } twc_line_in_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } twc_line_out_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic en;
    logic irq_en;
    logic [7:0] data;
    logic [7:0] rate;
    logic [1:0] presc;
    logic [4:0] code_pend;
    logic [4:0] code;
    twc_state_type st;
    logic rep;
    logic [1:0] q;
    logic [8:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic addr_phase;
    logic addr_rd;
    logic acked;
    logic sda_prev;
    logic irq;
    logic scl_oe;
    logic sda_oe;
  } twc_regs_type;

endpackage

// ===== verilog/twc_sync2.sv
// two-flop synchroniser for one line sampled from outside the clk_sys domain
// assumes clk_sys runs far faster than the bus lines toggle
`timescale 1ns/1ps
module twc_sync2 (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // line in and synchronised level out
  input wire logic d,
  output logic q
);

  logic meta_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
